// ---- rtl/vcr_pkg.sv ----
package vcr_pkg;
   // register byte offsets
   localparam logic [11:0] OFS_STATUS = 12'h004;
   localparam logic [11:0] OFS_SHUTDOWN_KEY = 12'h008;
   localparam logic [11:0] OFS_IRQ_ENABLE = 12'h200;
   localparam logic [11:0] OFS_IRQ_STATUS = 12'h204;
   localparam logic [11:0] OFS_IRQ_CLEAR = 12'h208;
   localparam logic [11:0] OFS_IRQ_SET = 12'h20c;
   // field positions, shared by all four interrupt registers
   localparam int BIT_FELL = 0;
   localparam int BIT_ROSE = 1;
   localparam int IRQ_W = 2;
   // status register fields
   localparam int BIT_COMPARE = 0;
   localparam int BIT_POWERED_DOWN = 1;
   // key and reset values
   localparam logic [31:0] SHUTDOWN_KEY_VALUE = 32'h0000_0037;
   localparam logic [31:0] SHUTDOWN_KEY_RESET = 32'h0000_0000;
   localparam logic [1:0] IRQ_RESET = 2'h0;
endpackage

// ---- rtl/vcr_regs.sv ----
// The implementer's own choice: the address-and-strobe port.
`timescale 1ns/10ps
// Summary of operation
// - A 32-bit read/write shutdown key register resets to zero and recognises the value 0x37.
// - Writing 0x37 to the key switches the comparator off; it is on from reset until then.
// - The enable register gates each event's interrupt: bit 1 rose, bit 0 fell.
// - The status register latches one flag per event at the enable bit positions, reset zero.
// - Writing one to a clear register bit resets that status flag; zero leaves it.
// - Writing one to a set register bit sets that status flag at once and raises the interrupt if that bit is enabled.
// - Bits 31 to 2 of the four interrupt registers read zero and ignore writes.
// - When enabled, the rose flag sets on a rising output or if high when its enable is set.
// - When enabled, the fell flag sets on a falling output or if low when its enable is set.
// - A read-only powered-down bit reads 1 while the comparator is off.
module vcr_regs (
   // clock and reset
   input wire logic i_core_clk,
   input wire logic i_reset,
   // register port
   input wire logic [11:0] i_addr,
   input wire logic [31:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   output logic [31:0] o_rdata,
   // comparator side
   input wire logic i_compare_result,
   output logic o_comparator_enable,
   output logic o_irq
);
   logic [31:0] shutdown_key_r;
   logic powered_down_r;
   logic [1:0] irq_enable_r;
   logic [1:0] irq_status_r;
   logic [1:0] irq_status_nxt;
   logic compare_prev_r;
   logic [1:0] event_hit;
   logic [1:0] newly_enabled;
   logic wr_enable;
   logic wr_clear;
   logic wr_set;
   logic [31:0] rdata_nxt;

   assign wr_enable = i_wr && (i_addr == vcr_pkg::OFS_IRQ_ENABLE);
   assign wr_clear = i_wr && (i_addr == vcr_pkg::OFS_IRQ_CLEAR);
   assign wr_set = i_wr && (i_addr == vcr_pkg::OFS_IRQ_SET);

   // key register; any value stored, only the key acts
   always_ff @(posedge i_core_clk) begin
      if (i_reset) begin
         shutdown_key_r <= vcr_pkg::SHUTDOWN_KEY_RESET;
      end else if (i_wr && (i_addr == vcr_pkg::OFS_SHUTDOWN_KEY)) begin
         shutdown_key_r <= i_wdata;
      end
   end

   // power-down latches on key; only reset powers back up, so a later write cannot undo it
   always_ff @(posedge i_core_clk) begin
      if (i_reset) begin
         powered_down_r <= 1'b0;
      end else if (i_wr && (i_addr == vcr_pkg::OFS_SHUTDOWN_KEY)
                   && (i_wdata == vcr_pkg::SHUTDOWN_KEY_VALUE)) begin
         powered_down_r <= 1'b1;
      end
   end

   // enable drives the comparator from a flop
   always_ff @(posedge i_core_clk) begin
      if (i_reset) begin
         o_comparator_enable <= 1'b1;
      end else if (i_wr && (i_addr == vcr_pkg::OFS_SHUTDOWN_KEY)
                   && (i_wdata == vcr_pkg::SHUTDOWN_KEY_VALUE)) begin
         o_comparator_enable <= 1'b0;
      end
   end

   // interrupt enable, low two bits only
   always_ff @(posedge i_core_clk) begin
      if (i_reset) begin
         irq_enable_r <= vcr_pkg::IRQ_RESET;
      end else if (wr_enable) begin
         irq_enable_r <= i_wdata[vcr_pkg::IRQ_W-1:0];
      end
   end

   // previous output level for edge detection
   always_ff @(posedge i_core_clk) begin
      if (i_reset) begin
         compare_prev_r <= 1'b0;
      end else begin
         compare_prev_r <= i_compare_result;
      end
   end

   // events: edges, plus level already present when the enable bit turns on
   always_comb begin
      newly_enabled = wr_enable ? (i_wdata[vcr_pkg::IRQ_W-1:0] & ~irq_enable_r) : 2'h0;
      event_hit[vcr_pkg::BIT_ROSE] = (irq_enable_r[vcr_pkg::BIT_ROSE]
         && i_compare_result && !compare_prev_r)
         || (newly_enabled[vcr_pkg::BIT_ROSE] && i_compare_result);
      event_hit[vcr_pkg::BIT_FELL] = (irq_enable_r[vcr_pkg::BIT_FELL]
         && !i_compare_result && compare_prev_r)
         || (newly_enabled[vcr_pkg::BIT_FELL] && !i_compare_result);
   end

   // status flags: set (event or soft set) wins over clear in the same cycle
   always_comb begin
      irq_status_nxt = irq_status_r;
      if (wr_clear) begin
         irq_status_nxt = irq_status_nxt & ~i_wdata[vcr_pkg::IRQ_W-1:0];
      end
      if (wr_set) begin
         irq_status_nxt = irq_status_nxt | i_wdata[vcr_pkg::IRQ_W-1:0];
      end
      irq_status_nxt = irq_status_nxt | event_hit;
   end

   always_ff @(posedge i_core_clk) begin
      if (i_reset) begin
         irq_status_r <= vcr_pkg::IRQ_RESET;
      end else begin
         irq_status_r <= irq_status_nxt;
      end
   end

   // interrupt follows the next-state so a soft set shows one cycle after the write
   always_ff @(posedge i_core_clk) begin
      if (i_reset) begin
         o_irq <= 1'b0;
      end else begin
         o_irq <= |(irq_status_nxt & (wr_enable ? i_wdata[vcr_pkg::IRQ_W-1:0]
                                                : irq_enable_r));
      end
   end

   // read mux; clear and set read as zero, unmapped reads zero
   always_comb begin
      rdata_nxt = 32'h0000_0000;
      unique case (i_addr)
         vcr_pkg::OFS_STATUS: begin
            rdata_nxt[vcr_pkg::BIT_COMPARE] = i_compare_result;
            rdata_nxt[vcr_pkg::BIT_POWERED_DOWN] = powered_down_r;
         end
         vcr_pkg::OFS_SHUTDOWN_KEY: rdata_nxt = shutdown_key_r;
         vcr_pkg::OFS_IRQ_ENABLE: rdata_nxt[vcr_pkg::IRQ_W-1:0] = irq_enable_r;
         vcr_pkg::OFS_IRQ_STATUS: rdata_nxt[vcr_pkg::IRQ_W-1:0] = irq_status_r;
         default: rdata_nxt = 32'h0000_0000;
      endcase
   end

   // read data valid only in the cycle after the strobe
   always_ff @(posedge i_core_clk) begin
      if (i_reset) begin
         o_rdata <= 32'h0000_0000;
      end else if (i_rd) begin
         o_rdata <= rdata_nxt;
      end else begin
         o_rdata <= 32'h0000_0000;
      end
   end

   property p_key_reset;
      @(posedge i_core_clk) $rose(i_reset) |=> (shutdown_key_r == vcr_pkg::SHUTDOWN_KEY_RESET);
   endproperty
   a_key_reset: assert property (p_key_reset) else $error("key not zero after reset");

   property p_key_off;
      @(posedge i_core_clk) disable iff (i_reset)
         (i_wr && i_addr == vcr_pkg::OFS_SHUTDOWN_KEY && i_wdata == vcr_pkg::SHUTDOWN_KEY_VALUE)
         |=> !o_comparator_enable ##1 !o_comparator_enable;
   endproperty
   a_key_off: assert property (p_key_off) else $error("key did not power down");

   // power-down is one way; only reset may bring the comparator back
   property p_pwd_hold;
      @(posedge i_core_clk) disable iff (i_reset)
         !o_comparator_enable |=> !o_comparator_enable;
   endproperty
   a_pwd_hold: assert property (p_pwd_hold) else $error("comparator powered back up");

   property p_gate;
      @(posedge i_core_clk) disable iff (i_reset)
         (irq_enable_r == vcr_pkg::IRQ_RESET && !wr_enable) |=> !o_irq;
   endproperty
   a_gate: assert property (p_gate) else $error("irq without enable");

   property p_clear;
      @(posedge i_core_clk) disable iff (i_reset)
         (wr_clear && i_wdata[vcr_pkg::BIT_FELL] && !wr_set
          && !event_hit[vcr_pkg::BIT_FELL]) |=> !irq_status_r[vcr_pkg::BIT_FELL];
   endproperty
   a_clear: assert property (p_clear) else $error("clear failed");

   property p_set;
      @(posedge i_core_clk) disable iff (i_reset)
         (wr_set && i_wdata[vcr_pkg::BIT_ROSE] && irq_enable_r[vcr_pkg::BIT_ROSE])
         |=> irq_status_r[vcr_pkg::BIT_ROSE] && o_irq;
   endproperty
   a_set: assert property (p_set) else $error("soft set failed");

   property p_rsvd;
      @(posedge i_core_clk) disable iff (i_reset)
         (i_rd && i_addr == vcr_pkg::OFS_IRQ_STATUS) |=> (o_rdata[31:2] == 30'h0);
   endproperty
   a_rsvd: assert property (p_rsvd) else $error("reserved bits not zero");

   property p_rise;
      @(posedge i_core_clk) disable iff (i_reset)
         (irq_enable_r[vcr_pkg::BIT_ROSE] && !compare_prev_r && i_compare_result)
         |=> irq_status_r[vcr_pkg::BIT_ROSE];
   endproperty
   a_rise: assert property (p_rise) else $error("rise missed");

   property p_fall;
      @(posedge i_core_clk) disable iff (i_reset)
         (irq_enable_r[vcr_pkg::BIT_FELL] && compare_prev_r && !i_compare_result)
         |=> irq_status_r[vcr_pkg::BIT_FELL];
   endproperty
   a_fall: assert property (p_fall) else $error("fall missed");

   property p_pwd;
      @(posedge i_core_clk) disable iff (i_reset)
         (i_rd && i_addr == vcr_pkg::OFS_STATUS)
         |=> (o_rdata[vcr_pkg::BIT_POWERED_DOWN] == !o_comparator_enable);
   endproperty
   a_pwd: assert property (p_pwd) else $error("powered-down bit wrong");

   property p_irq;
      @(posedge i_core_clk) disable iff (i_reset)
         (|(irq_status_r & irq_enable_r)) |-> o_irq;
   endproperty
   a_irq: assert property (p_irq) else $error("irq not asserted");
endmodule // vcr_regs

// ---- testbench/vcr_regs_tb.sv ----
`timescale 1ns/10ps
module vcr_regs_tb;
   logic clk;
   logic rst;
   logic [11:0] addr;
   logic [31:0] wdata;
   logic wr;
   logic rd;
   logic cmp;
   logic [31:0] rdata;
   logic cmp_en;
   logic irq;
   int err_total;
   int n_compared;

   // device under test
   vcr_regs u_dut (
      .i_core_clk(clk),
      .i_reset(rst),
      .i_addr(addr),
      .i_wdata(wdata),
      .i_wr(wr),
      .i_rd(rd),
      .o_rdata(rdata),
      .i_compare_result(cmp),
      .o_comparator_enable(cmp_en),
      .o_irq(irq)
   );

   // 10 MHz core clock
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   // one counted compare
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         err_total++;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   // single-cycle write strobe
   task automatic wr_reg(input logic [11:0] a, input logic [31:0] d);
      @(posedge clk);
      wr <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge clk);
      wr <= 1'b0;
   endtask

   // read data only stand in the cycle after the strobe, so look there
   task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp, input string nm);
      @(posedge clk);
      rd <= 1'b1;
      addr <= a;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      chk(nm, rdata, exp);
   endtask

   // interrupt level lags its cause by one edge
   task automatic irq_chk(input logic exp);
      @(posedge clk);
      #1;
      chk("irq", {31'h0, irq}, {31'h0, exp});
   endtask

   // comparator level change, given time to be sampled and flagged
   task automatic set_cmp(input logic v);
      @(posedge clk);
      cmp <= v;
      repeat (3) @(posedge clk);
   endtask

   task automatic final_report();
      if (err_total == 0 && n_compared > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   task automatic s_reset();
      rd_chk(vcr_pkg::OFS_SHUTDOWN_KEY, 32'h0, "key");
      rd_chk(vcr_pkg::OFS_IRQ_ENABLE, 32'h0, "enable");
      rd_chk(vcr_pkg::OFS_IRQ_STATUS, 32'h0, "status");
      rd_chk(vcr_pkg::OFS_IRQ_CLEAR, 32'h0, "clear");
      rd_chk(vcr_pkg::OFS_IRQ_SET, 32'h0, "set");
      rd_chk(12'h100, 32'h0, "unmapped");
      rd_chk(vcr_pkg::OFS_STATUS, 32'h0, "pwr_stat");
      chk("cmp_en", {31'h0, cmp_en}, 32'h1);
   endtask

   // soft set with reserved bits, gating and clearing
   task automatic s_soft();
      wr_reg(vcr_pkg::OFS_IRQ_SET, 32'hffff_ffff);
      rd_chk(vcr_pkg::OFS_IRQ_STATUS, 32'h3, "status");
      irq_chk(1'b0);
      wr_reg(vcr_pkg::OFS_IRQ_ENABLE, 32'hffff_ffff);
      irq_chk(1'b1);
      rd_chk(vcr_pkg::OFS_IRQ_ENABLE, 32'h3, "enable");
      wr_reg(vcr_pkg::OFS_IRQ_CLEAR, 32'h1);
      rd_chk(vcr_pkg::OFS_IRQ_STATUS, 32'h2, "status");
      wr_reg(vcr_pkg::OFS_IRQ_CLEAR, 32'hffff_fffc);
      rd_chk(vcr_pkg::OFS_IRQ_STATUS, 32'h2, "status");
      irq_chk(1'b1);
      wr_reg(vcr_pkg::OFS_IRQ_ENABLE, 32'h0);
      irq_chk(1'b0);
      wr_reg(vcr_pkg::OFS_IRQ_CLEAR, 32'h3);
      rd_chk(vcr_pkg::OFS_IRQ_STATUS, 32'h0, "status");
   endtask

   // comparator edges and levels present at enable time
   task automatic s_edge();
      wr_reg(vcr_pkg::OFS_IRQ_ENABLE, 32'h2);
      rd_chk(vcr_pkg::OFS_IRQ_STATUS, 32'h0, "status");
      set_cmp(1'b1);
      rd_chk(vcr_pkg::OFS_IRQ_STATUS, 32'h2, "status");
      irq_chk(1'b1);
      rd_chk(vcr_pkg::OFS_STATUS, 32'h1, "cmp_stat");
      wr_reg(vcr_pkg::OFS_IRQ_ENABLE, 32'h3);
      wr_reg(vcr_pkg::OFS_IRQ_CLEAR, 32'h3);
      rd_chk(vcr_pkg::OFS_IRQ_STATUS, 32'h0, "status");
      set_cmp(1'b0);
      rd_chk(vcr_pkg::OFS_IRQ_STATUS, 32'h1, "status");
      wr_reg(vcr_pkg::OFS_IRQ_ENABLE, 32'h0);
      wr_reg(vcr_pkg::OFS_IRQ_CLEAR, 32'h3);
      set_cmp(1'b1);
      rd_chk(vcr_pkg::OFS_IRQ_STATUS, 32'h0, "status");
      wr_reg(vcr_pkg::OFS_IRQ_ENABLE, 32'h2);
      rd_chk(vcr_pkg::OFS_IRQ_STATUS, 32'h2, "status");
      wr_reg(vcr_pkg::OFS_IRQ_ENABLE, 32'h1);
      wr_reg(vcr_pkg::OFS_IRQ_CLEAR, 32'h3);
      set_cmp(1'b0);
      rd_chk(vcr_pkg::OFS_IRQ_STATUS, 32'h1, "status");
      irq_chk(1'b1);
      // low level already present when the fell enable turns on
      wr_reg(vcr_pkg::OFS_IRQ_ENABLE, 32'h0);
      wr_reg(vcr_pkg::OFS_IRQ_CLEAR, 32'h3);
      wr_reg(vcr_pkg::OFS_IRQ_ENABLE, 32'h1);
      rd_chk(vcr_pkg::OFS_IRQ_STATUS, 32'h1, "status");
   endtask

   // only the exact key powers down, and only a reset powers up again
   task automatic s_key();
      wr_reg(vcr_pkg::OFS_SHUTDOWN_KEY, 32'ha5a5_5aa5);
      rd_chk(vcr_pkg::OFS_SHUTDOWN_KEY, 32'ha5a5_5aa5, "key");
      chk("cmp_en", {31'h0, cmp_en}, 32'h1);
      wr_reg(vcr_pkg::OFS_SHUTDOWN_KEY, 32'h36);
      rd_chk(vcr_pkg::OFS_SHUTDOWN_KEY, 32'h36, "key");
      chk("cmp_en", {31'h0, cmp_en}, 32'h1);
      wr_reg(vcr_pkg::OFS_SHUTDOWN_KEY, 32'h37);
      rd_chk(vcr_pkg::OFS_STATUS, 32'h2, "pwr_stat");
      chk("cmp_en", {31'h0, cmp_en}, 32'h0);
      wr_reg(vcr_pkg::OFS_SHUTDOWN_KEY, 32'h0);
      rd_chk(vcr_pkg::OFS_SHUTDOWN_KEY, 32'h0, "key");
      chk("cmp_en", {31'h0, cmp_en}, 32'h0);
      // mid-run reset is the one way back to a powered comparator
      @(posedge clk);
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      rd_chk(vcr_pkg::OFS_STATUS, 32'h0, "pwr_stat");
      chk("cmp_en", {31'h0, cmp_en}, 32'h1);
      rd_chk(vcr_pkg::OFS_IRQ_STATUS, 32'h0, "status");
      irq_chk(1'b0);
   endtask

   // main sequence
   initial begin
      err_total = 0;
      n_compared = 0;
      rst = 1'b1;
      addr = 12'h0;
      wdata = 32'h0;
      wr = 1'b0;
      rd = 1'b0;
      cmp = 1'b0;
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      s_reset();
      s_soft();
      s_edge();
      s_key();
      final_report();
   end
endmodule // vcr_regs_tb
